// *** core/gstc_pkg.sv ***
// Package with register map, field positions, encodings and timing constants for the timer.
package gstc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] GSTC_OFF_COUNT_LOW = 12'h000;
  localparam logic [11:0] GSTC_OFF_COUNT_HIGH = 12'h004;
  localparam logic [11:0] GSTC_OFF_TIMER_CTRL = 12'h008;
  localparam logic [11:0] GSTC_OFF_GATE_CTRL = 12'h00C;
  localparam logic [11:0] GSTC_OFF_STATUS = 12'h010;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GSTC_CTRL_ON_BIT = 0;
  localparam int GSTC_CTRL_SYNC_N_BIT = 2;
  localparam int GSTC_CTRL_PRE_LSB = 4;
  localparam int GSTC_CTRL_SRC_LSB = 6;
  localparam int GSTC_GATE_EN_BIT = 7;
  localparam int GSTC_GATE_POL_BIT = 6;
  localparam int GSTC_GATE_SEL_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GSTC_CTRL_RESET = 8'h00;
  localparam logic [7:0] GSTC_GATE_RESET = 8'h00;
  localparam logic [15:0] GSTC_COUNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Clock source encodings and timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GSTC_SRC_INSTR = 2'h0,
    GSTC_SRC_SYSOSC = 2'h1,
    GSTC_SRC_EXTPIN = 2'h2,
    GSTC_SRC_LFOSC = 2'h3
  } gstc_src_t;

  localparam int GSTC_INSTR_DIV = 4;
  localparam logic [15:0] GSTC_SYSOSC_STEP = 16'h0004;
  localparam int GSTC_LFOSC_DIV_DEFAULT = 1600;

endpackage : gstc_pkg

// *** core/gstc_sync.sv ***
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module gstc_sync
  import gstc_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : gstc_sync

// *** core/gstc_tick.sv ***
// Free-running divider that produces one-cycle ticks for internal count sources.
`timescale 1ns/1ps
module gstc_tick
  import gstc_pkg::*;
#(
  parameter int LF_DIV = GSTC_LFOSC_DIV_DEFAULT
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  output logic instr_tick,
  output logic lf_tick
);

  logic [1:0] q_cnt_q;
  logic [$clog2(LF_DIV+1)-1:0] lf_cnt_q;
  wire lf_wrap = (lf_cnt_q == ($clog2(LF_DIV+1))'(LF_DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_cnt_q <= 2'h0;
      lf_cnt_q <= '0;
      instr_tick <= 1'b0;
      lf_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      q_cnt_q <= q_cnt_q + 2'h1;
      instr_tick <= (q_cnt_q == 2'(GSTC_INSTR_DIV - 1));
      lf_cnt_q <= lf_wrap ? '0 : lf_cnt_q + 1'b1;
      lf_tick <= lf_wrap;
    end
  end

endmodule : gstc_tick

// *** core/gstc_timer.sv ***
// Gated sixteen-bit timer and counter with an APB register interface.
`timescale 1ns/1ps

// Contract
// - Sixteen-bit up-counter read as two bytes.
// - Byte write replaces that counter byte at once.
// - On bit off stops; gate enable gates.
// - Select: 11 slow, 10 pin, 01 system.
// - Internal sources pass through the prescaler.
// - System source adds four per instruction.
// - External mode counts pin rising edges.
// - Pin count synchronised or raw selectable.
// - Falling edge needed before first rising.
// - Gate from pin or either comparator.
module gstc_timer
  import gstc_pkg::*;
#(
  parameter int LF_DIV = GSTC_LFOSC_DIV_DEFAULT
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic gate_pin,
  input wire logic comp1_out,
  input wire logic comp2_out,
  output logic [15:0] count_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  gstc_sync #(.WIDTH(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_i({comp2_out, comp1_out, gate_pin, ext_count_pin}),
    .sync_o(pins_s)
  );

  logic instr_tick;
  logic lf_tick;
  gstc_tick #(.LF_DIV(LF_DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .instr_tick(instr_tick),
    .lf_tick(lf_tick)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] timer_control_reg_q;
  logic [7:0] gate_control_reg_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [2:0] pre_cnt_q;
  logic [2:0] pre_cnt_d;
  logic pin_prev_q;
  logic armed_q;
  logic armed_d;
  logic raw_pin_q;

  wire timer_on_bit = timer_control_reg_q[GSTC_CTRL_ON_BIT];
  wire sync_n_bit = timer_control_reg_q[GSTC_CTRL_SYNC_N_BIT];
  wire [1:0] pre_sel = timer_control_reg_q[GSTC_CTRL_PRE_LSB +: 2];
  wire gstc_src_t source_select_field = gstc_src_t'(timer_control_reg_q[GSTC_CTRL_SRC_LSB +: 2]);
  wire gate_enable_bit = gate_control_reg_q[GSTC_GATE_EN_BIT];
  wire gate_pol = gate_control_reg_q[GSTC_GATE_POL_BIT];
  wire [1:0] gate_sel = gate_control_reg_q[GSTC_GATE_SEL_LSB +: 2];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc = psel && penable && clk_en;
  wire wr = acc && pwrite;
  wire hit_lo = (paddr == GSTC_OFF_COUNT_LOW);
  wire hit_hi = (paddr == GSTC_OFF_COUNT_HIGH);
  wire hit_tc = (paddr == GSTC_OFF_TIMER_CTRL);
  wire hit_gc = (paddr == GSTC_OFF_GATE_CTRL);
  wire hit_st = (paddr == GSTC_OFF_STATUS);
  wire hit_any = hit_lo || hit_hi || hit_tc || hit_gc || hit_st;
  wire wr_lo = wr && hit_lo;
  wire wr_hi = wr && hit_hi;
  wire wr_count = wr_lo || wr_hi;

  // ----------------------------------------------------------------
  // Gate and enable
  // ----------------------------------------------------------------
  wire gate_src = (gate_sel == 2'h1) ? pins_s[1] :
                  (gate_sel == 2'h2) ? pins_s[3] : pins_s[2];
  wire gate_open = gate_src ^ gate_pol;
  wire run = timer_on_bit && (!gate_enable_bit || gate_open);

  // ----------------------------------------------------------------
  // Count source and prescaler
  // ----------------------------------------------------------------
  wire pin_cur = sync_n_bit ? raw_pin_q : pins_s[0];
  wire pin_rise = pin_cur && !pin_prev_q;
  wire pin_fall = !pin_cur && pin_prev_q;
  wire is_ext = (source_select_field == GSTC_SRC_EXTPIN);
  wire src_tick = (source_select_field == GSTC_SRC_LFOSC) ? lf_tick :
                  (source_select_field == GSTC_SRC_SYSOSC) ? instr_tick :
                  (source_select_field == GSTC_SRC_INSTR) ? instr_tick :
                  (pin_rise && armed_q);
  wire [2:0] pre_max = 3'((1 << pre_sel) - 1);
  wire pre_wrap = (pre_cnt_q >= pre_max);
  wire inc = run && src_tick && pre_wrap;
  wire [15:0] step = (source_select_field == GSTC_SRC_SYSOSC) ? GSTC_SYSOSC_STEP : 16'h0001;

  always_comb
  begin
    count_d = count_q;
    pre_cnt_d = pre_cnt_q;
    if (run && src_tick)
    begin
      pre_cnt_d = pre_wrap ? 3'h0 : pre_cnt_q + 3'h1;
    end
    if (inc)
    begin
      count_d = count_q + step;
    end
    if (wr_lo)
    begin
      count_d[7:0] = pwdata[7:0];
    end
    if (wr_hi)
    begin
      count_d[15:8] = pwdata[7:0];
    end
  end

  always_comb
  begin
    armed_d = armed_q;
    if (pin_fall)
    begin
      armed_d = 1'b1;
    end
    if (wr_count || !timer_on_bit || !is_ext)
    begin
      armed_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Raw pin sample for the unsynchronised mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      raw_pin_q <= 1'b0;
    else if (clk_en)
      raw_pin_q <= ext_count_pin;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= GSTC_COUNT_RESET;
      pre_cnt_q <= 3'h0;
      pin_prev_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      count_q <= count_d;
      pre_cnt_q <= wr_count ? 3'h0 : pre_cnt_d;
      pin_prev_q <= pin_cur;
      armed_q <= armed_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_reg_q <= GSTC_CTRL_RESET;
      gate_control_reg_q <= GSTC_GATE_RESET;
    end
    else if (clk_en)
    begin
      if (wr && hit_tc)
        timer_control_reg_q <= pwdata[7:0];
      if (wr && hit_gc)
        gate_control_reg_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data and response
  // ----------------------------------------------------------------
  wire [7:0] status_v = {5'h00, armed_q, gate_open, run};
  wire [7:0] rd_byte = hit_lo ? count_q[7:0] :
                       hit_hi ? count_q[15:8] :
                       hit_tc ? timer_control_reg_q :
                       hit_gc ? gate_control_reg_q :
                       hit_st ? status_v : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      count_o <= GSTC_COUNT_RESET;
    end
    else if (clk_en)
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= {24'h000000, rd_byte};
      count_o <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  byte_write_a: assert property (clk_en && wr_lo |=> count_q[7:0] == $past(pwdata[7:0]))
    else $error("Low byte write not applied.");
  high_write_a: assert property (clk_en && wr_hi |=> count_q[15:8] == $past(pwdata[7:0]))
    else $error("High byte write not applied.");
  off_hold_a: assert property (clk_en && !timer_on_bit && !wr_count |=> count_q == $past(count_q))
    else $error("Counter moved while off.");
  gate_hold_a: assert property (clk_en && gate_enable_bit && !gate_open && !wr_count
                                |=> count_q == $past(count_q))
    else $error("Counter moved while gate closed.");
  sys_step_a: assert property (clk_en && inc && !wr_count
                               && source_select_field == GSTC_SRC_SYSOSC
                               |=> count_q == $past(count_q) + 16'h0004)
    else $error("System source step is not four.");
  unit_step_a: assert property (clk_en && inc && !wr_count
                                && source_select_field != GSTC_SRC_SYSOSC
                                |=> count_q == $past(count_q) + 16'h0001)
    else $error("Counter step is not one.");
  arm_clear_a: assert property (clk_en && wr_count |=> !armed_q)
    else $error("Write did not disarm edge counting.");
  ext_arm_a: assert property (is_ext && !armed_q |-> !inc)
    else $error("Rising edge counted before falling edge.");
  prescale_a: assert property (clk_en && run && src_tick && !pre_wrap && !wr_count
                               |=> count_q == $past(count_q))
    else $error("Prescaler did not hold the count.");
  off_run_a: assert property (!timer_on_bit |-> !run)
    else $error("Run asserted while off.");
  rd_low_a: assert property (clk_en && psel && !penable && hit_lo
                             |=> prdata == {24'h000000, $past(count_q[7:0])})
    else $error("Low byte read data wrong.");
  rd_high_a: assert property (clk_en && psel && !penable && hit_hi
                              |=> prdata == {24'h000000, $past(count_q[15:8])})
    else $error("High byte read data wrong.");
  arm_fall_a: assert property (clk_en && is_ext && timer_on_bit && pin_fall && !wr_count
                               |=> armed_q)
    else $error("Falling edge did not arm counting.");
  arm_off_a: assert property (clk_en && !timer_on_bit |=> !armed_q)
    else $error("Disabled timer left edge counting armed.");
  lf_idle_a: assert property (clk_en && source_select_field == GSTC_SRC_LFOSC
                              && !lf_tick && !wr_count |=> count_q == $past(count_q))
    else $error("Slow source counted without a tick.");
  instr_idle_a: assert property (clk_en && !is_ext && source_select_field != GSTC_SRC_LFOSC
                                 && !instr_tick && !wr_count |=> count_q == $past(count_q))
    else $error("Instruction source counted without a tick.");
  ext_idle_a: assert property (clk_en && is_ext && !pin_rise && !wr_count
                               |=> count_q == $past(count_q))
    else $error("Pin source counted without a rising edge.");
  ext_count_a: assert property (clk_en && is_ext && run && armed_q && pin_rise
                                && pre_wrap && !wr_count
                                |=> count_q == $past(count_q) + 16'h0001)
    else $error("Armed rising edge not counted.");
  run_on_a: assert property (clk_en && timer_on_bit && !gate_enable_bit
                             && src_tick && pre_wrap && !wr_count
                             |=> count_q != $past(count_q))
    else $error("Ungated timer missed a count.");
  gate_count_a: assert property (clk_en && timer_on_bit && gate_enable_bit && gate_open
                                 && src_tick && pre_wrap && !wr_count
                                 |=> count_q != $past(count_q))
    else $error("Open gate missed a count.");

  ext_count_c: cover property (is_ext && inc);
  gated_count_c: cover property (gate_enable_bit && inc);
  sys_count_c: cover property (source_select_field == GSTC_SRC_SYSOSC && inc);
  raw_pin_c: cover property (is_ext && sync_n_bit && inc);
  lf_count_c: cover property (source_select_field == GSTC_SRC_LFOSC && inc);

endmodule : gstc_timer

// *** test/gstc_pin_model.sv ***
// Model of the external count pin and the asynchronous gate sources.
`timescale 1ns/1ps
module gstc_pin_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic [3:0] half,
  input wire logic [2:0] lvl,
  output logic busy,
  output logic ext_count_pin,
  output logic gate_pin,
  output logic comp1_out,
  output logic comp2_out
);
  assign comp1_out = lvl[0];
  assign gate_pin = lvl[1];
  assign comp2_out = lvl[2];

  // Pin rests low between bursts; each pulse is high then low for half cycles.
  initial
  begin
    busy = 1'b0;
    ext_count_pin = 1'b0;
  end

  always
  begin
    @(posedge pclk);
    if (go === 1'b1)
    begin
      busy <= 1'b1;
      for (int i = 0; i < n_pulses; i++)
      begin
        ext_count_pin <= 1'b1;
        repeat (half) @(posedge pclk);
        ext_count_pin <= 1'b0;
        repeat (half) @(posedge pclk);
      end
      busy <= 1'b0;
    end
  end
endmodule : gstc_pin_model

// *** test/tb_gated_sixteen_bit_timer_counter.sv ***
// Self-checking bench for the gated sixteen-bit timer.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb_gated_sixteen_bit_timer_counter
  import gstc_pkg::*;
;
  typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] q; logic e;} gstc_row_t;
  typedef struct packed {logic [7:0] g; logic [7:0] c; logic [7:0] lo; logic [7:0] hi;} gstc_cnt_t;
  logic pclk = 1'b0;
  logic presetn, clk_en, psel, penable, pwrite, pready, pslverr, err, go, busy;
  logic ext_count_pin, gate_pin, comp1_out, comp2_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] count_o, cnt;
  logic [7:0] n_pulses;
  logic [3:0] half;
  logic [2:0] lvl;
  int n_fail, checked, cyc;
  gstc_row_t rows [7] = '{'{GSTC_OFF_COUNT_LOW, 8'hA5, 8'hA5, 1'b0},
    '{GSTC_OFF_COUNT_HIGH, 8'h3C, 8'h3C, 1'b0}, '{GSTC_OFF_GATE_CTRL, 8'hC2, 8'hC2, 1'b0},
    '{GSTC_OFF_TIMER_CTRL, 8'hF4, 8'hF4, 1'b0}, '{12'h014, 8'hFF, 8'h00, 1'b1},
    '{GSTC_OFF_TIMER_CTRL, 8'h00, 8'h00, 1'b0}, '{GSTC_OFF_GATE_CTRL, 8'h00, 8'h00, 1'b0}};
  gstc_cnt_t crows [10] = '{'{8'h00, 8'h01, 8'd9, 8'd12}, '{8'h00, 8'h41, 8'd36, 8'd48},
    '{8'h00, 8'hC1, 8'd9, 8'd12}, '{8'h00, 8'h11, 8'd4, 8'd6}, '{8'h00, 8'h00, 8'd0, 8'd0},
    '{8'h81, 8'h01, 8'd0, 8'd0}, '{8'hC1, 8'h01, 8'd9, 8'd12}, '{8'h80, 8'h01, 8'd9, 8'd12},
    '{8'h82, 8'h01, 8'd0, 8'd0}, '{8'h80, 8'h00, 8'd0, 8'd0}};

  always #10 pclk = ~pclk;

  gstc_timer #(.LF_DIV(4)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin), .gate_pin(gate_pin),
    .comp1_out(comp1_out), .comp2_out(comp2_out), .count_o(count_o));

  gstc_pin_model u_pin (.pclk(pclk), .go(go), .n_pulses(n_pulses), .half(half), .lvl(lvl),
    .busy(busy), .ext_count_pin(ext_count_pin), .gate_pin(gate_pin), .comp1_out(comp1_out),
    .comp2_out(comp2_out));

  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_cnt;
    apb(1'b0, GSTC_OFF_COUNT_LOW, 8'h00);
    cnt[7:0] = rd[7:0];
    apb(1'b0, GSTC_OFF_COUNT_HIGH, 8'h00);
    cnt[15:8] = rd[7:0];
  endtask : rd_cnt

  task pulses(input logic [7:0] n, input logic [3:0] h);
    int t;
    n_pulses <= n;
    half <= h;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    t = 0;
    do begin @(posedge pclk); t++; end while (busy !== 1'b0 && t < 300);
    repeat (4) @(posedge pclk);
  endtask : pulses

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      finish_test;
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {n_fail, checked, cyc} = '0;
    {presetn, psel, penable, pwrite, go} = '0;
    {paddr, pwdata, n_pulses} = '0;
    clk_en = 1'b1;
    half = 4'h4;
    lvl = 3'b001;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(4 * i), 8'h00);
      `CHK("reset value", 32'h0, rd)
    end
    `CHK("count_o reset", 16'h0000, count_o)
    $display("test reset done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00);
      `CHK("read data", {24'h0, rows[i].q}, rd)
      `CHK("slave error", rows[i].e, err)
    end
    `CHK("count_o bytes", 16'h3CA5, count_o)
    $display("test registers done");
    foreach (crows[i])
    begin
      apb(1'b1, GSTC_OFF_COUNT_LOW, 8'h00);
      apb(1'b1, GSTC_OFF_COUNT_HIGH, 8'h00);
      apb(1'b1, GSTC_OFF_GATE_CTRL, crows[i].g);
      apb(1'b1, GSTC_OFF_TIMER_CTRL, crows[i].c);
      repeat (40) @(posedge pclk);
      apb(1'b1, GSTC_OFF_TIMER_CTRL, 8'h00);
      rd_cnt;
      `CHK("count range", 1'b1, (cnt >= crows[i].lo && cnt <= crows[i].hi))
      if (crows[i].c[7:6] == 2'h1)
        `CHK("system step", 2'h0, cnt[1:0])
    end
    $display("test sources done");
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, GSTC_OFF_COUNT_LOW, 8'h00);
      apb(1'b1, GSTC_OFF_COUNT_HIGH, 8'h00);
      apb(1'b1, GSTC_OFF_TIMER_CTRL, 8'h81 | 8'(m << 2));
      pulses(8'd3, (m == 0) ? 4'h6 : 4'h2);
      rd_cnt;
      `CHK("pin count", 16'h0002, cnt)
      apb(1'b1, GSTC_OFF_COUNT_LOW, 8'h10);
      apb(1'b1, GSTC_OFF_COUNT_HIGH, 8'h12);
      pulses(8'd2, 4'h4);
      rd_cnt;
      `CHK("pin after write", 16'h1211, cnt)
      apb(1'b1, GSTC_OFF_TIMER_CTRL, 8'h00);
    end
    $display("test pin done");
    apb(1'b1, GSTC_OFF_TIMER_CTRL, 8'h41);
    repeat (8) @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    cnt = count_o;
    repeat (20) @(posedge pclk);
    `CHK("clock enable hold", cnt, count_o)
    clk_en <= 1'b1;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("count_o in reset", 16'h0000, count_o)
    presetn <= 1'b1;
    rd_cnt;
    `CHK("count after reset", 16'h0000, cnt)
    $display("test hold and reset done");
    finish_test;
  end
endmodule : tb_gated_sixteen_bit_timer_counter
